/* File: hdl/rru_pkg.sv */
// package of opcode patterns, phase codes and reset values for the rotate unit
package rru_pkg;

    // ************************************************************
    // opcode patterns, upper seven bits of the instruction word
    // ************************************************************
    localparam logic [6:0] RRU_OP_RLNC     = 7'h11;  // 0010 001d
    localparam logic [6:0] RRU_OP_RRC      = 7'h0c;  // 0001 100d
    localparam logic [6:0] RRU_OP_RRNC     = 7'h10;  // 0010 000d
    localparam int         RRU_DEST_BIT    = 8;
    localparam int         RRU_OPC_MSB     = 15;
    localparam int         RRU_OPC_LSB     = 9;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RRU_ACC_RESET   = 8'h00;
    localparam logic       RRU_CARRY_RESET = 1'b0;
    localparam logic [15:0] RRU_INSN_RESET = 16'h0000;

    typedef enum logic [1:0] {
        RRU_OP_NONE,
        RRU_OP_LEFT_NC,
        RRU_OP_RIGHT_C,
        RRU_OP_RIGHT_NC
    } rru_op_t;

    typedef enum {
        RRU_Q1,
        RRU_Q2,
        RRU_Q3,
        RRU_Q4
    } rru_phase_t;

endpackage : rru_pkg

/* File: hdl/rru_rotator.sv */
// combinational rotate datapath for the three rotate operations
`timescale 1ns/1ps

module rru_rotator
    import rru_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] operand,
    input  wire rru_op_t          op,
    input  wire logic             carry_in,
    output logic      [WIDTH-1:0] result,
    output logic                  carry_out
);

    // ************************************************************
    // rotate
    // ************************************************************
    always_comb begin
        result    = operand;
        carry_out = carry_in;
        case (op)
            RRU_OP_LEFT_NC: begin
                result = {operand[WIDTH-2:0], operand[WIDTH-1]};
            end
            RRU_OP_RIGHT_C: begin
                result    = {carry_in, operand[WIDTH-1:1]};
                carry_out = operand[0];
            end
            RRU_OP_RIGHT_NC: begin
                result = {operand[0], operand[WIDTH-1:1]};
            end
            default: begin
                result = operand;
            end
        endcase
    end

endmodule : rru_rotator

/* File: hdl/rru_unit.sv */
// four-phase rotate unit: decode, file read, rotate and destination write
`timescale 1ns/1ps

module rru_unit
    import rru_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             insn_valid,
    input  wire logic [15:0]      insn,
    output logic      [7:0]       file_addr,
    output logic                  file_rd,
    input  wire logic [WIDTH-1:0] file_rdata,
    output logic                  file_wr,
    output logic      [WIDTH-1:0] file_wdata,
    output logic      [WIDTH-1:0] working_accumulator,
    output logic                  carry,
    output logic                  busy,
    output logic                  done
);

    // ************************************************************
    // state
    // ************************************************************
    rru_phase_t       phase,     next_phase;
    logic [15:0]      insn_q,    next_insn_q;
    rru_op_t          op,        next_op;
    logic             dest,      next_dest;
    logic [WIDTH-1:0] operand,   next_operand;
    logic [WIDTH-1:0] res,       next_res;
    logic             res_c,     next_res_c;
    logic [WIDTH-1:0] acc,       next_acc;
    logic             cflag,     next_cflag;
    logic             wr,        next_wr;
    logic [WIDTH-1:0] wdata,     next_wdata;
    logic             rd,        next_rd;
    logic             fin,       next_fin;
    logic [WIDTH-1:0] rot_result;
    logic             rot_carry;

    function automatic rru_op_t rru_decode(input logic [15:0] word);
        logic [6:0] opc;
        opc = word[RRU_OPC_MSB:RRU_OPC_LSB];
        if (opc == RRU_OP_RLNC) begin
            return RRU_OP_LEFT_NC;
        end else if (opc == RRU_OP_RRC) begin
            return RRU_OP_RIGHT_C;
        end else if (opc == RRU_OP_RRNC) begin
            return RRU_OP_RIGHT_NC;
        end else begin
            return RRU_OP_NONE;
        end
    endfunction : rru_decode

    rru_rotator #(
        .WIDTH (WIDTH)
    ) u_rot (
        .operand   (operand),
        .op        (op),
        .carry_in  (cflag),
        .result    (rot_result),
        .carry_out (rot_carry)
    );

    // ************************************************************
    // phase sequencer
    // ************************************************************
    always_comb begin
        next_phase   = phase;
        next_insn_q  = insn_q;
        next_op      = op;
        next_dest    = dest;
        next_operand = operand;
        next_res     = res;
        next_res_c   = res_c;
        next_acc     = acc;
        next_cflag   = cflag;
        next_wr      = 1'b0;
        next_wdata   = wdata;
        next_rd      = 1'b0;
        next_fin     = 1'b0;
        case (phase)
            RRU_Q1: begin
                // unknown opcodes are ignored so other units can own them
                if (insn_valid && rru_decode(insn) != RRU_OP_NONE) begin
                    next_insn_q = insn;
                    next_op     = rru_decode(insn);
                    next_dest   = insn[RRU_DEST_BIT];
                    next_rd     = 1'b1;
                    next_phase  = RRU_Q2;
                end
            end
            RRU_Q2: begin
                next_operand = file_rdata;
                next_phase   = RRU_Q3;
            end
            RRU_Q3: begin
                next_res   = rot_result;
                next_res_c = rot_carry;
                next_phase = RRU_Q4;
            end
            RRU_Q4: begin
                if (dest) begin
                    next_wr    = 1'b1;
                    next_wdata = res;
                end else begin
                    next_acc = res;
                end
                // only the through-carry form touches the flag
                if (op == RRU_OP_RIGHT_C) begin
                    next_cflag = res_c;
                end
                next_fin   = 1'b1;
                next_phase = RRU_Q1;
            end
            default: begin
                next_phase = RRU_Q1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase   <= RRU_Q1;
            insn_q  <= RRU_INSN_RESET;
            op      <= RRU_OP_NONE;
            dest    <= 1'b0;
            operand <= RRU_ACC_RESET;
            res     <= RRU_ACC_RESET;
            res_c   <= RRU_CARRY_RESET;
            acc     <= RRU_ACC_RESET;
            cflag   <= RRU_CARRY_RESET;
            wr      <= 1'b0;
            wdata   <= RRU_ACC_RESET;
            rd      <= 1'b0;
            fin     <= 1'b0;
        end else begin
            phase   <= next_phase;
            insn_q  <= next_insn_q;
            op      <= next_op;
            dest    <= next_dest;
            operand <= next_operand;
            res     <= next_res;
            res_c   <= next_res_c;
            acc     <= next_acc;
            cflag   <= next_cflag;
            wr      <= next_wr;
            wdata   <= next_wdata;
            rd      <= next_rd;
            fin     <= next_fin;
        end
    end

    assign file_addr           = insn_q[7:0];
    assign file_rd             = rd;
    assign file_wr             = wr;
    assign file_wdata          = wdata;
    assign working_accumulator = acc;
    assign carry               = cflag;
    assign busy                = (phase != RRU_Q1);
    assign done                = fin;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_left_wraps_bit: assert property (
        (phase == RRU_Q3 && op == RRU_OP_LEFT_NC) |=>
            res == {$past(operand[WIDTH-2:0]), $past(operand[WIDTH-1])})
        else $error("left rotate result wrong");
    a_left_keeps_carry: assert property (
        (phase == RRU_Q4 && op != RRU_OP_RIGHT_C) |=> $stable(carry))
        else $error("carry changed by no-carry rotate");
    a_dest_file_write: assert property (
        (phase == RRU_Q4 && dest) |=> file_wr && file_wdata == $past(res) && $stable(acc))
        else $error("file destination not written");
    a_dest_acc_write: assert property (
        (phase == RRU_Q4 && !dest) |=> !file_wr && working_accumulator == $past(res))
        else $error("accumulator destination not written");
    a_rrc_result: assert property (
        (phase == RRU_Q3 && op == RRU_OP_RIGHT_C) |=>
            res == {$past(cflag), $past(operand[WIDTH-1:1])} && res_c == $past(operand[0]))
        else $error("through-carry rotate wrong");
    a_rrc_carry_update: assert property (
        (phase == RRU_Q4 && op == RRU_OP_RIGHT_C) |=> carry == $past(res_c))
        else $error("carry not updated");
    a_rrnc_result: assert property (
        (phase == RRU_Q3 && op == RRU_OP_RIGHT_NC) |=>
            res == {$past(operand[0]), $past(operand[WIDTH-1:1])})
        else $error("right no-carry rotate wrong");
    a_four_phases: assert property (
        (phase == RRU_Q1 && insn_valid && rru_decode(insn) != RRU_OP_NONE) |=>
            file_rd ##1 busy ##1 busy ##1 (done && !busy))
        else $error("instruction not done in four phases");
    a_illegal_ignored: assert property (
        (phase == RRU_Q1 && !(insn_valid && rru_decode(insn) != RRU_OP_NONE)) |=> !busy)
        else $error("foreign opcode accepted");
    // refused requests while busy must not disturb the latched address
    a_busy_holds_addr: assert property (
        busy |=> $stable(file_addr))
        else $error("file address moved while busy");
    a_done_one_pulse: assert property (
        done |=> !done)
        else $error("done held past one cycle");

    c_left_file: cover property (phase == RRU_Q4 && op == RRU_OP_LEFT_NC && dest);
    c_rrc_acc: cover property (phase == RRU_Q4 && op == RRU_OP_RIGHT_C && !dest);
    c_rrnc_file: cover property (phase == RRU_Q4 && op == RRU_OP_RIGHT_NC && dest);
    c_back_to_back: cover property (done && insn_valid && rru_decode(insn) != RRU_OP_NONE);

endmodule : rru_unit

/* File: verification/tb_top.sv */
// self-checking testbench for the four-phase rotate unit
`timescale 1ns/1ps

module tb_top;
    import rru_pkg::*;

    logic        clk;
    logic        arst_n;
    logic        insn_valid;
    logic [15:0] insn;
    logic [7:0]  file_addr;
    logic        file_rd;
    logic [7:0]  file_rdata;
    logic        file_wr;
    logic [7:0]  file_wdata;
    logic [7:0]  working_accumulator;
    logic        carry;
    logic        busy;
    logic        done;
    int          n_errors;
    int          samples_checked;
    int          cycles;
    logic [7:0]  exp_acc;
    logic        exp_c;

    rru_unit #(.WIDTH(8)) dut_u (
        .clk                 (clk),
        .arst_n              (arst_n),
        .insn_valid          (insn_valid),
        .insn                (insn),
        .file_addr           (file_addr),
        .file_rd             (file_rd),
        .file_rdata          (file_rdata),
        .file_wr             (file_wr),
        .file_wdata          (file_wdata),
        .working_accumulator (working_accumulator),
        .carry               (carry),
        .busy                (busy),
        .done                (done)
    );

    // ************************************************************
    // clock, timeout and reporting
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // fewer than 60 cycles are needed; the ceiling of 1000 leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            summarize();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task summarize;
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // ************************************************************
    // one rotate instruction, judged at its done pulse
    // ************************************************************
    task do_op(input logic [6:0] op, input logic dest, input logic [7:0] addr,
               input logic [7:0] data, input logic inject);
        int         n;
        int         rds;
        logic [7:0] res;
        logic       c;
        c = exp_c;
        case (op)
            RRU_OP_RLNC: res = {data[6:0], data[7]};
            RRU_OP_RRC: begin
                res = {exp_c, data[7:1]};
                c   = data[0];
            end
            default: res = {data[0], data[7:1]};
        endcase
        @(posedge clk); #1;
        insn_valid = 1'b1;
        insn       = {op, dest, addr};
        file_rdata = data;
        @(posedge clk); #1;
        n   = 1;
        rds = 0;
        check(file_addr, addr);
        while (done !== 1'b1 && n < 10) begin
            if (file_rd === 1'b1) rds++;
            // a second request while busy must leave no trace
            insn_valid = inject && n == 2;
            insn       = {RRU_OP_RRNC, 1'b1, ~addr};
            @(posedge clk); #1;
            n++;
        end
        insn_valid = 1'b0;
        check(n, 4);
        check(rds, 1);
        check(file_wr, dest);
        if (dest) check(file_wdata, res);
        else exp_acc = res;
        check(working_accumulator, exp_acc);
        check(carry, c);
        check(file_addr, addr);
        exp_c = c;
    endtask : do_op

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_reset;
        check({busy, done, file_rd, file_wr, carry, working_accumulator}, 0);
        $display("test reset done");
    endtask : t_reset

    task t_left;
        do_op(RRU_OP_RLNC, 1'b1, 8'h21, 8'heb, 1'b0);
        do_op(RRU_OP_RLNC, 1'b0, 8'h7f, 8'h80, 1'b0);
        $display("test left done");
    endtask : t_left

    task t_rrc;
        do_op(RRU_OP_RRC, 1'b0, 8'h05, 8'he6, 1'b0);
        do_op(RRU_OP_RRC, 1'b1, 8'hff, 8'h01, 1'b0);
        do_op(RRU_OP_RRC, 1'b0, 8'h00, 8'h01, 1'b0);
        do_op(RRU_OP_RLNC, 1'b0, 8'h10, 8'h55, 1'b0);
        $display("test rrc done");
    endtask : t_rrc

    task t_rrnc;
        do_op(RRU_OP_RRNC, 1'b1, 8'h42, 8'hd7, 1'b0);
        do_op(RRU_OP_RRNC, 1'b0, 8'h42, 8'hd7, 1'b0);
        $display("test rrnc done");
    endtask : t_rrnc

    task t_busy;
        do_op(RRU_OP_RRC, 1'b0, 8'h3c, 8'h81, 1'b1);
        $display("test busy done");
    endtask : t_busy

    task t_unknown;
        @(posedge clk); #1;
        insn_valid = 1'b1;
        insn       = {7'h0d, 1'b0, 8'h33};
        @(posedge clk); #1;
        insn_valid = 1'b0;
        repeat (5) begin
            check({busy, done, file_rd, file_wr}, 0);
            @(posedge clk); #1;
        end
        check({carry, working_accumulator}, {exp_c, exp_acc});
        $display("test unknown done");
    endtask : t_unknown

    initial begin
        n_errors        = 0;
        samples_checked = 0;
        cycles          = 0;
        exp_acc         = RRU_ACC_RESET;
        exp_c           = RRU_CARRY_RESET;
        arst_n          = 1'b0;
        insn_valid      = 1'b0;
        insn            = RRU_INSN_RESET;
        file_rdata      = 8'h00;
        repeat (2) @(posedge clk);
        #1;
        t_reset();
        arst_n = 1'b1;
        t_left();
        t_rrc();
        t_rrnc();
        t_busy();
        t_unknown();
        summarize();
    end

endmodule : tb_top
